//--- shared/rfa_pkg.sv
package rfa_pkg;

    localparam int DATA_WIDTH = 32;
    localparam int FIELD_COUNT = 32;
    localparam logic [31:0] ALL_ZERO = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;

    // Field attribute codes, one per bit position
    typedef enum logic [3:0]
    {
        ATTR_RESERVED = 4'h0,
        ATTR_HARDWARE_INITIALIZED_FIELD_FIELD = 4'h1,
        ATTR_READ_CLEAR = 4'h2,
        ATTR_READ_CLEAR_WRITABLE = 4'h3,
        ATTR_READ_ONLY = 4'h4,
        ATTR_READ_WRITE = 4'h5,
        ATTR_WRITE_ONE_CLEAR = 4'h6,
        ATTR_WRITE_WHEN_UNLOCKED = 4'h7,
        ATTR_WRITE_TRANSIENT = 4'h8,
        ATTR_ZERO = 4'h9
    } rfa_attr_e;

    // Write source selectors
    localparam logic [1:0] SRC_ROOT = 2'h0;
    localparam logic [1:0] SRC_SMBUS = 2'h1;
    localparam logic [1:0] SRC_EEPROM = 2'h2;

    // Load phases of the hardware-initialised fields
    typedef enum logic [1:0]
    {
        LOAD_OPEN = 2'b01,
        LOAD_LOCKED = 2'b10
    } rfa_load_e;

endpackage

//--- src/rfa_hold_reg.sv
`timescale 1ns/1ps
module rfa_hold_reg
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [31:0] resetValue,
    input wire logic [31:0] next_value,
    output logic [31:0] value
);
    // Reset loads the per-instance reset image so every field class starts from its default
    logic [31:0] stored;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            stored <= resetValue;
        end
        else
        begin
            stored <= next_value;
        end
    end

    assign value = stored;
endmodule

//--- src/register_field_access_semantics.sv
`timescale 1ns/1ps
module register_field_access_semantics
#(
    parameter logic [127:0] FIELD_ATTR = {32{4'h5}},
    parameter logic [31:0] RESET_VALUE = 32'h0000_0000,
    parameter logic [31:0] CONST_VALUE = 32'h0000_0000
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic rootWrite,
    input wire logic [31:0] rootData,
    input wire logic smbusWrite,
    input wire logic [31:0] smbusData,
    input wire logic eepromWrite,
    input wire logic [31:0] eepromData,
    input wire logic [31:0] writeMask,
    input wire logic readStrobe,
    input wire logic [31:0] strapValue,
    input wire logic strapLoad,
    input wire logic initDone,
    input wire logic [31:0] hwSet,
    input wire logic [31:0] hwClear,
    input wire logic register_unlock_bit,
    output logic [31:0] readData,
    output logic readValid,
    output logic [31:0] fieldValue,
    output logic zeroViolation
);

    function automatic rfa_pkg::rfa_attr_e attrOf(input int idx);
        attrOf = rfa_pkg::rfa_attr_e'(FIELD_ATTR[idx*4 +: 4]);
    endfunction

    // Bits under the enable take the new data, the rest keep their old value
    function automatic logic [31:0] mergeBits(input logic [31:0] old, input logic [31:0] data,
        input logic [31:0] en);
        mergeBits = (old & ~en) | (data & en);
    endfunction

    // Per-bit attribute masks
    logic [31:0] isHwinit, isRc, isRcw, isRo, isRw, isW1c, isRwl, isWt, isZero, isRsvd;
    always_comb
    begin
        for (int i = 0; i < 32; i++)
        begin
            isHwinit[i] = (attrOf(i) == rfa_pkg::ATTR_HARDWARE_INITIALIZED_FIELD_FIELD);
            isRc[i] = (attrOf(i) == rfa_pkg::ATTR_READ_CLEAR);
            isRcw[i] = (attrOf(i) == rfa_pkg::ATTR_READ_CLEAR_WRITABLE);
            isRo[i] = (attrOf(i) == rfa_pkg::ATTR_READ_ONLY);
            isRw[i] = (attrOf(i) == rfa_pkg::ATTR_READ_WRITE);
            isW1c[i] = (attrOf(i) == rfa_pkg::ATTR_WRITE_ONE_CLEAR);
            isRwl[i] = (attrOf(i) == rfa_pkg::ATTR_WRITE_WHEN_UNLOCKED);
            isWt[i] = (attrOf(i) == rfa_pkg::ATTR_WRITE_TRANSIENT);
            isZero[i] = (attrOf(i) == rfa_pkg::ATTR_ZERO);
            isRsvd[i] = (attrOf(i) == rfa_pkg::ATTR_RESERVED);
        end
    end

    // Source merge: root wins, then SMBus, then EEPROM; one write per cycle
    wire anyWrite = rootWrite | smbusWrite | eepromWrite;
    wire [31:0] writeData = rootWrite ? rootData : (smbusWrite ? smbusData : eepromData);

    // Transient bits in the register gate the rest of the write when any exist
    wire [31:0] wtHit = writeData & writeMask & isWt;
    wire qualified = (isWt == rfa_pkg::ALL_ZERO) || (wtHit != rfa_pkg::ALL_ZERO);
    wire doWrite = anyWrite & qualified;
    wire [31:0] wrEn = doWrite ? writeMask : rfa_pkg::ALL_ZERO;

    rfa_pkg::rfa_load_e loadState;
    logic [31:0] value;
    logic [31:0] next_value;
    wire loadOpen = (loadState == rfa_pkg::LOAD_OPEN);

    // Hardware-initialised load window closes on initDone until next reset
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            loadState <= rfa_pkg::LOAD_OPEN;
        end
        else
        begin
            case (loadState)
                rfa_pkg::LOAD_OPEN: if (initDone) loadState <= rfa_pkg::LOAD_LOCKED;
                rfa_pkg::LOAD_LOCKED: loadState <= rfa_pkg::LOAD_LOCKED;
                default: loadState <= rfa_pkg::LOAD_OPEN;
            endcase
        end
    end

    localparam logic [31:0] ALL_ON = rfa_pkg::ALL_ONES;
    // No read-only bit is constant: CONST_VALUE_MASK is zero, so all follow hwSet and hwClear
    localparam logic [31:0] CONST_VALUE_MASK = 32'h0000_0000;
    wire [31:0] isRoConst = isRo & CONST_VALUE_MASK;

    // Only a write that really carries EEPROM data may load; a colliding root write wins the bus
    wire eepromOnly = eepromWrite & ~rootWrite & ~smbusWrite;
    wire [31:0] hwinitStrap = (loadOpen && strapLoad) ? ALL_ON : rfa_pkg::ALL_ZERO;
    wire [31:0] hwinitWrite = (loadOpen && eepromOnly && qualified) ? writeMask
        : rfa_pkg::ALL_ZERO;
    wire [31:0] unlockEn = register_unlock_bit ? ALL_ON : rfa_pkg::ALL_ZERO;
    wire [31:0] readClr = readStrobe ? ALL_ON : rfa_pkg::ALL_ZERO;

    wire [31:0] rcNext = (value & ~readClr) | hwSet;
    wire [31:0] rcwNext = mergeBits(value & ~readClr, writeData, wrEn) | hwSet;
    wire [31:0] roNext = (value | hwSet) & ~hwClear;
    wire [31:0] rwNext = mergeBits(value, writeData, wrEn);
    wire [31:0] w1cNext = (value & ~(writeData & wrEn)) | hwSet;
    wire [31:0] rwlEn = wrEn & unlockEn;
    wire [31:0] rwlNext = mergeBits(value, writeData, rwlEn);
    wire [31:0] hwNext = (value & ~hwinitStrap & ~hwinitWrite)
        | (strapValue & hwinitStrap & ~hwinitWrite) | (writeData & hwinitWrite);

    always_comb
    begin
        next_value = (isRc & rcNext) | (isRcw & rcwNext) | (isRo & ~isRoConst & roNext)
            | (isRw & rwNext) | (isW1c & w1cNext) | (isRwl & rwlNext) | (isHwinit & hwNext)
            | (isRoConst & CONST_VALUE);
    end

    rfa_hold_reg u_hold
    (
        .mclk(mclk),
        .rst(rst),
        .resetValue(RESET_VALUE),
        .next_value(next_value),
        .value(value)
    );

    // Transient, zero and reserved positions all read zero
    wire [31:0] visible = ~(isWt | isZero | isRsvd);
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            readData <= rfa_pkg::ALL_ZERO;
            readValid <= 1'b0;
            zeroViolation <= 1'b0;
        end
        else
        begin
            readData <= readStrobe ? (value & visible) : rfa_pkg::ALL_ZERO;
            readValid <= readStrobe;
            zeroViolation <= anyWrite && ((writeData & writeMask & isZero) != 0);
        end
    end

    assign fieldValue = value & visible;

    // Checks
    chk_w1c_set_wins: assert property (@(posedge mclk) disable iff (rst)
        ((hwSet & isW1c) != 0) |=> ((value & $past(hwSet) & isW1c) == ($past(hwSet) & isW1c)))
        else $error("w1c set lost");
    chk_w1c_no_hwclr: assert property (@(posedge mclk) disable iff (rst)
        !anyWrite |=> ((~value & $past(value) & isW1c) == 0))
        else $error("w1c cleared without write");
    chk_rc_clears: assert property (@(posedge mclk) disable iff (rst)
        readStrobe && ((hwSet & isRc) == 0) |=> ((value & isRc) == 0))
        else $error("read-clear not cleared");
    chk_rw_stores: assert property (@(posedge mclk) disable iff (rst)
        doWrite |=> ((value & isRw & $past(writeMask))
        == ($past(writeData) & isRw & $past(writeMask))))
        else $error("rw not stored");
    chk_rwl_locked: assert property (@(posedge mclk) disable iff (rst)
        !register_unlock_bit |=> ((value & isRwl) == ($past(value) & isRwl)))
        else $error("rwl changed while locked");
    chk_zero_reads: assert property (@(posedge mclk) disable iff (rst)
        readStrobe |=> readValid && ((readData & (isZero | isWt)) == 0))
        else $error("zero field read nonzero");
    chk_hardware_initialized_field_frozen: assert property (@(posedge mclk) disable iff (rst)
        !loadOpen |=> ((value & isHwinit) == ($past(value) & isHwinit)))
        else $error("hardware_initialized_field changed after load");
    chk_rcw_write: assert property (@(posedge mclk) disable iff (rst)
        doWrite && ((hwSet & isRcw) == 0) |=>
        ((value & isRcw & $past(writeMask)) == ($past(writeData) & isRcw & $past(writeMask))))
        else $error("rcw write lost");
    chk_ro_nowrite: assert property (@(posedge mclk) disable iff (rst)
        anyWrite && (hwSet == 0) && (hwClear == 0) |=> ((value & isRo) == ($past(value) & isRo)))
        else $error("ro changed by write");
    chk_wt_gates: assert property (@(posedge mclk) disable iff (rst)
        anyWrite && !qualified |=> ((value & isRw) == ($past(value) & isRw)))
        else $error("unqualified write took effect");

    // Antecedent steps shared by the field-class checks below
    sequence seqW1cQuietWrite;
        doWrite && ((hwSet & isW1c) == rfa_pkg::ALL_ZERO);
    endsequence

    sequence seqRcwQuietRead;
        readStrobe && !doWrite && ((hwSet & isRcw) == rfa_pkg::ALL_ZERO);
    endsequence

    sequence seqRcQuietWrite;
        anyWrite && !readStrobe && ((hwSet & isRc) == rfa_pkg::ALL_ZERO);
    endsequence

    sequence seqUnlockedWrite;
        doWrite && register_unlock_bit;
    endsequence

    sequence seqEepromLoad;
        loadOpen && eepromOnly && qualified && !strapLoad;
    endsequence

    sequence seqZeroWrite;
        anyWrite && ((writeData & writeMask & isZero) != rfa_pkg::ALL_ZERO);
    endsequence

    chk_rc_write_ignored: assert property (@(posedge mclk) disable iff (rst)
        seqRcQuietWrite
        |=> ((value & isRc) == ($past(value) & isRc)))
        else $error("read-clear changed by write");

    chk_rcw_read_clear: assert property (@(posedge mclk) disable iff (rst)
        seqRcwQuietRead
        |=> ((value & isRcw) == rfa_pkg::ALL_ZERO))
        else $error("read-clear-writable not cleared");

    chk_rw_hold: assert property (@(posedge mclk) disable iff (rst)
        !doWrite
        |=> ((value & isRw) == ($past(value) & isRw)))
        else $error("rw changed without write");

    chk_w1c_write_clears: assert property (@(posedge mclk) disable iff (rst)
        seqW1cQuietWrite
        |=> ((value & isW1c & $past(writeData) & $past(writeMask)) == rfa_pkg::ALL_ZERO))
        else $error("w1c one not cleared");

    chk_w1c_zero_keeps: assert property (@(posedge mclk) disable iff (rst)
        doWrite
        |=> (($past(value) & isW1c & ~$past(writeData) & ~value) == rfa_pkg::ALL_ZERO))
        else $error("w1c cleared by zero");

    chk_w1c_set_only_hw: assert property (@(posedge mclk) disable iff (rst)
        ((hwSet & isW1c) == rfa_pkg::ALL_ZERO)
        |=> ((value & ~$past(value) & isW1c) == rfa_pkg::ALL_ZERO))
        else $error("w1c set without event");

    chk_rwl_unlocked: assert property (@(posedge mclk) disable iff (rst)
        seqUnlockedWrite
        |=> ((value & isRwl & $past(writeMask)) == ($past(writeData) & isRwl & $past(writeMask))))
        else $error("rwl write lost while unlocked");

    chk_hardware_initialized_field_load: assert property (@(posedge mclk) disable iff (rst)
        seqEepromLoad
        |=> ((value & isHwinit & $past(writeMask))
        == ($past(writeData) & isHwinit & $past(writeMask))))
        else $error("hardware_initialized_field load lost");

    chk_ro_status: assert property (@(posedge mclk) disable iff (rst)
        ((hwSet & ~hwClear & isRo & ~isRoConst) != rfa_pkg::ALL_ZERO)
        |=> (($past(hwSet) & ~$past(hwClear) & isRo & ~isRoConst & ~value) == rfa_pkg::ALL_ZERO))
        else $error("ro status not set");

    chk_rc_set_wins: assert property (@(posedge mclk) disable iff (rst)
        ((hwSet & isRc) != rfa_pkg::ALL_ZERO)
        |=> ((value & $past(hwSet) & isRc) == ($past(hwSet) & isRc)))
        else $error("rc set lost");

    chk_rcw_set_wins: assert property (@(posedge mclk) disable iff (rst)
        ((hwSet & isRcw) != rfa_pkg::ALL_ZERO)
        |=> ((value & $past(hwSet) & isRcw) == ($past(hwSet) & isRcw)))
        else $error("rcw set lost");

    chk_zero_flag: assert property (@(posedge mclk) disable iff (rst)
        seqZeroWrite
        |=> zeroViolation)
        else $error("zero field write not flagged");

    chk_no_zero_flag: assert property (@(posedge mclk) disable iff (rst)
        !anyWrite
        |=> !zeroViolation)
        else $error("zero flag without write");

    chk_read_returns: assert property (@(posedge mclk) disable iff (rst)
        readStrobe
        |=> (readData == ($past(value) & visible)))
        else $error("read data not stored value");

    chk_read_idle: assert property (@(posedge mclk) disable iff (rst)
        !readStrobe
        |=> (!readValid && (readData == rfa_pkg::ALL_ZERO)))
        else $error("read data shown without read");

endmodule

//--- tb/rfa_sources.sv
`timescale 1ns/1ps
module rfa_sources
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic go,
    input wire logic [1:0] src,
    input wire logic [31:0] data,
    output logic rootWrite,
    output logic smbusWrite,
    output logic eepromWrite,
    output logic [31:0] rootData,
    output logic [31:0] smbusData,
    output logic [31:0] eepromData
);
    wire logic pickRoot = go && (src == rfa_pkg::SRC_ROOT);
    wire logic pickSmbus = go && (src == rfa_pkg::SRC_SMBUS);
    wire logic pickEeprom = go && (src == rfa_pkg::SRC_EEPROM);

    // Idle buses show the inverse of their last value, so stale data is never a safe match
    always_ff @(posedge mclk)
    begin
        rootWrite <= !rst && pickRoot;
        smbusWrite <= !rst && pickSmbus;
        eepromWrite <= !rst && pickEeprom;
        rootData <= rst ? 32'h0000_0000 : (pickRoot ? data : ~rootData);
        smbusData <= rst ? 32'h0000_0000 : (pickSmbus ? data : ~smbusData);
        eepromData <= rst ? 32'h0000_0000 : (pickEeprom ? data : ~eepromData);
    end
endmodule

//--- tb/register_field_access_semantics_bench.sv
`timescale 1ns/1ps
module register_field_access_semantics_bench;
    localparam logic [127:0] ATTR = {4'h8, 4'h4, 4'h0, 4'h9, {4{4'h4}}, {4{4'h1}},
        {4{4'h7}}, {4{4'h6}}, {4{4'h3}}, {4{4'h2}}, {4{4'h5}}};
    localparam logic [31:0] Q = 32'h8000_0000;
    logic mclk = 1'b0, rst = 1'b1, go = 1'b0, readStrobe = 1'b0;
    logic strapLoad = 1'b0, initDone = 1'b0, unlock = 1'b0;
    logic [1:0] src = 2'h0;
    logic [31:0] data = 32'h0000_0000, strapValue = 32'h0000_0000;
    logic [31:0] hwSet = 32'h0000_0000, hwClear = 32'h0000_0000;
    logic [31:0] mask = 32'hFFFF_FFFF;
    logic rW, sW, eW, readValid, zeroViolation;
    logic [31:0] rD, sD, eD, readData, fieldValue;
    int failures = 0, tests_run = 0, cycles = 0;
    rfa_sources i_src (.mclk(mclk), .rst(rst), .go(go), .src(src), .data(data),
        .rootWrite(rW), .smbusWrite(sW), .eepromWrite(eW),
        .rootData(rD), .smbusData(sD), .eepromData(eD));
    register_field_access_semantics #(.FIELD_ATTR(ATTR)) i_dut (.mclk(mclk), .rst(rst),
        .rootWrite(rW), .rootData(rD), .smbusWrite(sW), .smbusData(sD),
        .eepromWrite(eW), .eepromData(eD), .writeMask(mask),
        .readStrobe(readStrobe), .strapValue(strapValue), .strapLoad(strapLoad),
        .initDone(initDone), .hwSet(hwSet), .hwClear(hwClear), .register_unlock_bit(unlock),
        .readData(readData), .readValid(readValid), .fieldValue(fieldValue),
        .zeroViolation(zeroViolation));
    always #12.5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge mclk);
        #2;
    endtask
    // The source model registers go, so the strobe reaches the block one edge later
    task automatic wr(input logic [1:0] s, input logic [31:0] d, input logic [31:0] hs);
        src = s;
        data = d;
        go = 1'b1;
        tick();
        go = 1'b0;
        hwSet = hs;
        tick();
        hwSet = 32'h0000_0000;
    endtask
    task automatic rd();
        readStrobe = 1'b1;
        tick();
        readStrobe = 1'b0;
        check("valid", {31'h0000_0000, readValid}, 32'h0000_0001);
    endtask
    task automatic hw(input logic [31:0] s, input logic [31:0] c);
        hwSet = s;
        hwClear = c;
        tick();
        hwSet = 32'h0000_0000;
        hwClear = 32'h0000_0000;
    endtask
    // Read-merge-write keeps reserved and zero bits at what was read, which is zero
    task automatic rmw(input logic [31:0] v, input logic [31:0] m);
        rd();
        wr(rfa_pkg::SRC_ROOT, (readData & ~m) | (v & m) | Q, 32'h0000_0000);
    endtask
    task automatic t_sources();
        for (int s = 0; s < 3; s++)
        begin
            wr(2'(s), Q | (32'(s) + 32'h0000_0005), 32'h0000_0000);
            check("store", fieldValue & 32'h0000_000F, 32'(s) + 32'h0000_0005);
            check("nozero", {31'h0000_0000, zeroViolation}, 32'h0000_0000);
            rd();
            check("readback", readData & 32'h8000_000F, 32'(s) + 32'h0000_0005);
        end
        wr(rfa_pkg::SRC_ROOT, 32'h0000_000A, 32'h0000_0000);
        check("unqualified", fieldValue & 32'h0000_000F, 32'h0000_0007);
        mask = 32'h8000_0003;
        wr(rfa_pkg::SRC_ROOT, Q | 32'h0000_000C, 32'h0000_0000);
        mask = rfa_pkg::ALL_ONES;
        check("masked", fieldValue & 32'h0000_000F, 32'h0000_0004);
        $display("test sources done");
    endtask
    task automatic t_readonly();
        wr(rfa_pkg::SRC_ROOT, rfa_pkg::ALL_ONES, 32'h0000_0000);
        check("zeroflag", {31'h0000_0000, zeroViolation}, 32'h0000_0001);
        check("fixed", fieldValue & 32'hFF0F_00F0, 32'h0000_0000);
        hw(32'h0100_0000, 32'h0000_0000);
        check("status", fieldValue & 32'h0100_0000, 32'h0100_0000);
        hw(32'h0000_0000, 32'h0100_0000);
        check("status", fieldValue & 32'h0100_0000, 32'h0000_0000);
        hw(32'h0000_00F0, 32'h0000_0000);
        rd();
        check("rdclr", readData & 32'h0000_0FF0, 32'h0000_0FF0);
        check("cleared", fieldValue & 32'h0000_0FF0, 32'h0000_0000);
        wr(rfa_pkg::SRC_ROOT, Q | 32'h0000_0A50, 32'h0000_0000);
        check("rdclrwr", fieldValue & 32'h0000_0FF0, 32'h0000_0A00);
        $display("test readonly done");
    endtask
    task automatic t_oneclear();
        hw(32'h0000_F000, 32'h0000_0000);
        wr(rfa_pkg::SRC_ROOT, Q, 32'h0000_0000);
        check("w0", fieldValue & 32'h0000_F000, 32'h0000_F000);
        wr(rfa_pkg::SRC_ROOT, Q | 32'h0000_3000, 32'h0000_0000);
        check("w1", fieldValue & 32'h0000_F000, 32'h0000_C000);
        hw(32'h0000_0000, 32'h0000_4000);
        check("hwclr", fieldValue & 32'h0000_F000, 32'h0000_C000);
        wr(rfa_pkg::SRC_SMBUS, Q | 32'h0000_8000, 32'h0000_8000);
        check("collide", fieldValue & 32'h0000_F000, 32'h0000_C000);
        $display("test oneclear done");
    endtask
    task automatic t_unlock();
        rmw(32'h000A_0000, 32'h000F_0000);
        check("locked", fieldValue & 32'h000F_0000, 32'h0000_0000);
        unlock = 1'b1;
        rmw(32'h000A_0000, 32'h000F_0000);
        check("unlocked", fieldValue & 32'h000F_0000, 32'h000A_0000);
        $display("test unlock done");
    endtask
    task automatic t_strap();
        strapValue = 32'h00A0_0000;
        strapLoad = 1'b1;
        tick();
        strapLoad = 1'b0;
        check("strap", fieldValue & 32'h00F0_0000, 32'h00A0_0000);
        wr(rfa_pkg::SRC_EEPROM, Q | 32'h0050_0000, 32'h0000_0000);
        check("load", fieldValue & 32'h00F0_0000, 32'h0050_0000);
        initDone = 1'b1;
        tick();
        initDone = 1'b0;
        wr(rfa_pkg::SRC_EEPROM, Q | 32'h00F0_0000, 32'h0000_0000);
        strapLoad = 1'b1;
        tick();
        strapLoad = 1'b0;
        check("sealed", fieldValue & 32'h00F0_0000, 32'h0050_0000);
        rst = 1'b1;
        repeat (2) tick();
        rst = 1'b0;
        check("reset", fieldValue, 32'h0000_0000);
        wr(rfa_pkg::SRC_EEPROM, Q | 32'h0030_0000, 32'h0000_0000);
        check("reopen", fieldValue & 32'h00F0_0000, 32'h0030_0000);
        $display("test strap done");
    endtask
    initial
    begin
        repeat (5) tick();
        rst = 1'b0;
        t_sources();
        t_readonly();
        t_oneclear();
        t_unlock();
        t_strap();
        final_report();
    end
endmodule
